// [hdl/cis_status_top.sv]
// card interface status register bank with APB slave and interrupt flags
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module cis_status_top #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // command engine side, same clock
  input wire logic seq_end_i,
  input wire logic end_with_busy_i,
  input wire logic cmd_sent_i,
  input wire logic rx_full_det_i,
  input wire logic tx_empty_det_i,
  input wire logic [7:0] irq_event_lo_i,
  input wire logic [7:0] irq_event_hi_i,
  output logic sequence_abort_o,
  output logic command_launch_o,
  output logic spi_mode_o,
  // card pins and link clock, asynchronous; irq_o registered on clock_i
  input wire logic card_data_pin_i,
  input wire logic spi_receive_pin_i,
  input wire logic link_clk_i,
  output logic irq_o
);
  typedef struct packed {
    cis_pkg::cis_seq_e seq;
    logic rx_full;
    logic tx_empty;
    logic permit;
    logic spi_mode;
    logic level;
    logic [7:0] en_lo;
    logic [7:0] en_hi;
    logic [7:0] fl_lo;
    logic [7:0] fl_hi;
    logic abort_p;
    logic launch_p;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cis_state_s;

  cis_state_s st;
  cis_state_s next_st;
  cis_pins_if pins ();

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  cis_pin_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .card_data_pin_i(card_data_pin_i),
    .spi_receive_pin_i(spi_receive_pin_i),
    .link_clk_i(link_clk_i),
    .pins(pins)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  // zero-extend a byte register into the bus word
  function automatic logic [31:0] cis_word(input logic [7:0] b);
    cis_word = {24'h00_0000, b};
  endfunction : cis_word

  // assemble the status byte from current state
  function automatic logic [7:0] cis_status(input cis_state_s s);
    logic [7:0] v;
    v = cis_pkg::RST_BYTE;
    v[cis_pkg::ST_BUSY] = (s.seq == cis_pkg::SEQ_RUN);
    v[cis_pkg::ST_RXFULL] = s.rx_full;
    v[cis_pkg::ST_TXEMPTY] = s.tx_empty;
    v[cis_pkg::ST_PERMIT] = s.permit;
    v[cis_pkg::ST_DBUSY] = (s.seq == cis_pkg::SEQ_DBUSY);
    v[cis_pkg::ST_LEVEL] = s.level;
    v[cis_pkg::ST_RSVD] = 1'b0;
    v[cis_pkg::ST_REQ] = |{s.fl_lo, s.fl_hi};
    cis_status = v;
  endfunction : cis_status

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic access;
    logic wr;
    logic seq_done;
    logic [7:0] clr_lo;
    logic [7:0] clr_hi;
    logic hit;
    logic [31:0] rd;
    access = 1'b0;
    wr = 1'b0;
    seq_done = 1'b0;
    clr_lo = 8'h00;
    clr_hi = 8'h00;
    hit = 1'b0;
    rd = cis_pkg::RST_WORD;
    next_st = st;
    next_st.abort_p = 1'b0;
    next_st.launch_p = 1'b0;

    // apb: one wait cycle, then ready; write acts on the ready edge only
    access = psel_i & penable_i & st.pready;
    wr = access & pwrite_i;
    next_st.pready = psel_i & penable_i & ~st.pready;

    // read mux and decode, latched in the cycle ready rises
    unique case (paddr_i)
      cis_pkg::OFS_STATUS: begin
        hit = 1'b1;
        rd = cis_word(cis_status(st));
      end
      cis_pkg::OFS_OPCTL: begin
        hit = 1'b1;
        rd = cis_word({5'h00, st.spi_mode, 2'h0});
      end
      cis_pkg::OFS_EN_LO: begin
        hit = 1'b1;
        rd = cis_word(st.en_lo);
      end
      cis_pkg::OFS_EN_HI: begin
        hit = 1'b1;
        rd = cis_word(st.en_hi);
      end
      cis_pkg::OFS_FL_LO: begin
        hit = 1'b1;
        rd = cis_word(st.fl_lo);
      end
      cis_pkg::OFS_FL_HI: begin
        hit = 1'b1;
        rd = cis_word(st.fl_hi);
      end
      cis_pkg::OFS_CLR: begin
        hit = 1'b1; // write-only, reads zero
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (next_st.pready) begin
      next_st.prdata = pwrite_i ? cis_pkg::RST_WORD : rd;
      next_st.pslverr = ~hit;
    end else begin
      next_st.pslverr = 1'b0;
    end

    // register writes; status and flag offsets ignore writes
    if (wr && hit) begin
      unique case (paddr_i)
        cis_pkg::OFS_OPCTL: begin
          next_st.spi_mode = pwdata_i[cis_pkg::OPC_SPI];
          next_st.abort_p = pwdata_i[cis_pkg::OPC_ABORT];
          // launch ignored while running; abort takes priority
          next_st.launch_p = pwdata_i[cis_pkg::OPC_LAUNCH] & ~pwdata_i[cis_pkg::OPC_ABORT]
            & (st.seq != cis_pkg::SEQ_RUN);
        end
        cis_pkg::OFS_EN_LO: begin
          next_st.en_lo = pwdata_i[7:0];
        end
        cis_pkg::OFS_EN_HI: begin
          next_st.en_hi = pwdata_i[7:0] & cis_pkg::EN_HI_MASK;
        end
        cis_pkg::OFS_CLR: begin
          clr_lo = pwdata_i[7:0];
          clr_hi = pwdata_i[15:8];
        end
        default: begin
          next_st.spi_mode = st.spi_mode;
        end
      endcase
    end

    // pin level of the line selected by the mode
    next_st.level = st.spi_mode ? pins.spi_level : pins.data_level;

    // sequence tracking
    seq_done = (st.seq == cis_pkg::SEQ_RUN) & (seq_end_i | next_st.abort_p);
    unique case (st.seq)
      cis_pkg::SEQ_IDLE: begin
        if (next_st.launch_p) begin
          next_st.seq = cis_pkg::SEQ_RUN;
        end
      end
      cis_pkg::SEQ_RUN: begin
        if (next_st.abort_p) begin
          next_st.seq = cis_pkg::SEQ_IDLE;
        end else if (seq_end_i) begin
          // card pulls the line low while busy
          next_st.seq = (end_with_busy_i && !st.level) ? cis_pkg::SEQ_DBUSY
            : cis_pkg::SEQ_IDLE;
        end
      end
      cis_pkg::SEQ_DBUSY: begin
        if (st.level) begin
          next_st.seq = cis_pkg::SEQ_IDLE;
        end else if (next_st.launch_p) begin
          next_st.seq = cis_pkg::SEQ_RUN;
        end
      end
    endcase

    // fifo pause bits; a detect wins over a resume in the same cycle
    if (rx_full_det_i) begin
      next_st.rx_full = 1'b1;
    end else if (seq_done || (st.rx_full && pins.link_rise)) begin
      next_st.rx_full = 1'b0;
    end
    if (tx_empty_det_i) begin
      next_st.tx_empty = 1'b1;
    end else if (seq_done || (st.tx_empty && pins.link_rise)) begin
      next_st.tx_empty = 1'b0;
    end

    // command write permit
    if (next_st.launch_p) begin
      next_st.permit = 1'b1;
    end else if (cmd_sent_i || seq_done) begin
      next_st.permit = 1'b0;
    end

    // sticky flags: set only if enabled, set wins over clear
    next_st.fl_lo = (st.fl_lo & ~clr_lo) | (irq_event_lo_i & st.en_lo);
    next_st.fl_hi = (st.fl_hi & ~clr_hi) | (irq_event_hi_i & st.en_hi);
    next_st.irq = |{next_st.fl_lo & next_st.en_lo, next_st.fl_hi & next_st.en_hi};
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign sequence_abort_o = st.abort_p;
  assign command_launch_o = st.launch_p;
  assign spi_mode_o = st.spi_mode;
  assign irq_o = st.irq;
endmodule : cis_status_top

// [hdl/cis_pkg.sv]
// constants, field layout and types of the card interface status block
package cis_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_OPCTL = 8'h04;
  localparam logic [7:0] OFS_EN_LO = 8'h08;
  localparam logic [7:0] OFS_EN_HI = 8'h0c;
  localparam logic [7:0] OFS_FL_LO = 8'h10;
  localparam logic [7:0] OFS_FL_HI = 8'h14;
  localparam logic [7:0] OFS_CLR = 8'h18;

  // ****************************************************************
  // status field positions
  // ****************************************************************
  localparam int unsigned ST_BUSY = 7;
  localparam int unsigned ST_RXFULL = 6;
  localparam int unsigned ST_TXEMPTY = 5;
  localparam int unsigned ST_PERMIT = 4;
  localparam int unsigned ST_DBUSY = 3;
  localparam int unsigned ST_LEVEL = 2;
  localparam int unsigned ST_RSVD = 1;
  localparam int unsigned ST_REQ = 0;

  // ****************************************************************
  // operation control fields and masks
  // ****************************************************************
  localparam int unsigned OPC_ABORT = 0;
  localparam int unsigned OPC_LAUNCH = 1;
  localparam int unsigned OPC_SPI = 2;
  localparam logic [7:0] EN_HI_MASK = 8'he7;
  localparam int unsigned HI_CMD_TIMEOUT = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ****************************************************************
  // sequence tracking states
  // ****************************************************************
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RUN,
    SEQ_DBUSY
  } cis_seq_e;
endpackage : cis_pkg

// [hdl/cis_pins_if.sv]
// synchronised card pin levels and link clock edge passed to the status core
`timescale 1ns/10ps
interface cis_pins_if;
  logic data_level;
  logic spi_level;
  logic link_rise;
  modport src (output data_level, output spi_level, output link_rise);
  modport dst (input data_level, input spi_level, input link_rise);
endinterface : cis_pins_if

// [hdl/cis_pin_sync.sv]
// two-flop synchronisers for card pins and link clock edge finder
`timescale 1ns/10ps
module cis_pin_sync #(
  parameter int unsigned STAGES = 2
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic card_data_pin_i,
  input wire logic spi_receive_pin_i,
  input wire logic link_clk_i,
  cis_pins_if.src pins
);
  typedef struct packed {
    logic [STAGES-1:0] dat;
    logic [STAGES-1:0] spi;
    logic [STAGES-1:0] clk;
    logic clk_last;
    logic rise;
  } cis_sync_s;

  cis_sync_s st;
  cis_sync_s next_st;

  // fewer than two stages would let metastability reach the core
  if (STAGES < 2) begin : g_chk
    $error("cis_pin_sync needs at least two stages");
  end

  // shift chains; only the last stage is ever looked at
  always_comb begin
    next_st = st;
    next_st.dat = {st.dat[STAGES-2:0], card_data_pin_i};
    next_st.spi = {st.spi[STAGES-2:0], spi_receive_pin_i};
    next_st.clk = {st.clk[STAGES-2:0], link_clk_i};
    next_st.clk_last = st.clk[STAGES-1];
    next_st.rise = st.clk[STAGES-1] & ~st.clk_last;
  end

  // register all sync state
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pins.data_level = st.dat[STAGES-1];
  assign pins.spi_level = st.spi[STAGES-1];
  assign pins.link_rise = st.rise;
endmodule : cis_pin_sync

// [bench/cis_status_props.sv]
// port assertions of the card interface status block
`timescale 1ns/10ps
module cis_status_props (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sequence_abort_o,
  input wire logic command_launch_o,
  input wire logic spi_mode_o,
  input wire logic card_data_pin_i,
  input wire logic spi_receive_pin_i,
  input wire logic irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic rd_st;
  logic wr_opc;
  // completed status read and operation control write
  assign rd_st = psel_i && penable_i && pready_o && !pwrite_i && paddr_i == cis_pkg::OFS_STATUS;
  assign wr_opc = psel_i && penable_i && pready_o && pwrite_i && paddr_i == cis_pkg::OFS_OPCTL;
  sequence s_setup_access;
    psel_i && !penable_i ##1 psel_i && penable_i && !pready_o;
  endsequence
  // pins and mode quiet long enough for the synchroniser to settle
  sequence s_pins_quiet;
    $stable({spi_mode_o, card_data_pin_i, spi_receive_pin_i}) [*6];
  endsequence
  access_wait_a: assert property (s_setup_access |=> pready_o)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (pready_o && (paddr_i > 8'h18 || paddr_i[1:0] != 2'b00)
    |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
  abort_pulse_a: assert property (wr_opc && pwdata_i[cis_pkg::OPC_ABORT]
    |=> sequence_abort_o && !command_launch_o) else $error("abort write lost");
  launch_cause_a: assert property (command_launch_o
    |-> $past(wr_opc && pwdata_i[cis_pkg::OPC_LAUNCH] && !pwdata_i[cis_pkg::OPC_ABORT]))
    else $error("launch without launch write");
  status_bits_a: assert property (rd_st
    |-> prdata_o[31:8] == 24'h0 && !prdata_o[cis_pkg::ST_RSVD]) else $error("reserved set");
  req_sum_a: assert property (rd_st && $past(irq_o) |-> prdata_o[cis_pkg::ST_REQ])
    else $error("request bit low with irq high");
  pin_level_a: assert property (s_pins_quiet ##1 rd_st
    |-> prdata_o[cis_pkg::ST_LEVEL] == $past(spi_mode_o ? spi_receive_pin_i : card_data_pin_i))
    else $error("pin level bit wrong");
endmodule : cis_status_props
bind cis_status_top cis_status_props u_props (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .sequence_abort_o(sequence_abort_o), .command_launch_o(command_launch_o),
  .spi_mode_o(spi_mode_o), .card_data_pin_i(card_data_pin_i),
  .spi_receive_pin_i(spi_receive_pin_i), .irq_o(irq_o));

// [bench/cis_card_model.sv]
// behavioural card: link clock, data line and spi receive line
`timescale 1ns/10ps
module cis_card_model (
  input wire logic frame_i,
  input wire logic busy_i,
  input wire logic spi_lvl_i,
  output logic link_clk_o,
  output logic data_o,
  output logic spi_o
);
  // 200 ns link clock, odd start offset so its edges fall half a nanosecond ahead of system clock edges
  initial begin
    link_clk_o = 1'b0;
    #37;
    forever begin
      #100;
      link_clk_o = frame_i ? ~link_clk_o : 1'b0; // stands low between frames
    end
  end
  // busy card pulls the line low; released line goes to the pull-up
  assign data_o = busy_i ? 1'b0 : 1'b1;
  assign spi_o = spi_lvl_i;
endmodule : cis_card_model

// [bench/testbench.sv]
// self-checking testbench of the card interface status block
`timescale 1ns/10ps
module testbench;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] padr = 8'h00, ev_lo = 8'h00, ev_hi = 8'h00, m;
  logic [31:0] pwd = 32'h0, prd, rdat;
  logic [3:0] eng = 4'h0; // seq end, cmd sent, rx full, tx empty
  logic ewb = 1'b0, frame = 1'b0, busy = 1'b0, spil = 1'b0, rerr;
  logic prdy, perr, abrt, lnch, spim, irq, lclk, dpin, spin;
  int mismatches = 0, samples_checked = 0, launches = 0, aborts = 0;
  always #12.5 clock_i = ~clock_i;
  // count the one-cycle engine pulses; each stands for a whole cycle
  always @(posedge clock_i) begin
    if (lnch === 1'b1) launches++;
    if (abrt === 1'b1) aborts++;
  end
  cis_card_model card (.frame_i(frame), .busy_i(busy), .spi_lvl_i(spil), .link_clk_o(lclk),
    .data_o(dpin), .spi_o(spin));
  cis_status_top DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .seq_end_i(eng[0]), .end_with_busy_i(ewb),
    .cmd_sent_i(eng[1]), .rx_full_det_i(eng[2]), .tx_empty_det_i(eng[3]),
    .irq_event_lo_i(ev_lo), .irq_event_hi_i(ev_hi), .sequence_abort_o(abrt),
    .command_launch_o(lnch), .spi_mode_o(spim), .card_data_pin_i(dpin),
    .spi_receive_pin_i(spin), .link_clk_i(lclk), .irq_o(irq));
  // ****************************************************************
  // tasks and expectations
  // ****************************************************************
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; the leading edge keeps back-to-back calls apart
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clock_i);
    end while (prdy !== 1'b1);
    rdat = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask : rd
  task pulse(input logic [3:0] p);
    @(posedge clock_i);
    eng <= p;
    @(posedge clock_i);
    eng <= 4'h0;
    repeat (6) @(posedge clock_i);
  endtask : pulse
  task evt(input logic [7:0] lo, input logic [7:0] hi);
    @(posedge clock_i);
    ev_lo <= lo;
    ev_hi <= hi;
    @(posedge clock_i);
    ev_lo <= 8'h00;
    ev_hi <= 8'h00;
  endtask : evt
  // status word from {busy, rx, tx, permit, dbusy, level, req}
  function automatic logic [31:0] st(input logic [6:0] b);
    st = {24'h0, b[6:1], 1'b0, b[0]};
  endfunction : st
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    report_and_stop;
  end
  initial begin
    void'($urandom(22805));
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    rd(cis_pkg::OFS_STATUS, st(7'b0000010));
    apb(1'b1, cis_pkg::OFS_STATUS, $urandom());
    rd(cis_pkg::OFS_STATUS, st(7'b0000010));
    for (int i = 1; i < 6; i++) rd(8'(4 * i), 32'h0);
    apb(1'b0, 8'h1e, 32'h0);
    check({31'h0, rerr}, 32'h1);
    apb(1'b1, cis_pkg::OFS_EN_HI, 32'hff);
    rd(cis_pkg::OFS_EN_HI, {24'h0, cis_pkg::EN_HI_MASK});
    apb(1'b1, cis_pkg::OFS_EN_HI, 32'h0);
    // full run: permit, rx full cleared by link clock, tx empty cleared at end
    apb(1'b1, cis_pkg::OFS_OPCTL, 32'h2);
    rd(cis_pkg::OFS_STATUS, st(7'b1001010));
    pulse(4'h2);
    apb(1'b1, cis_pkg::OFS_OPCTL, 32'h2);
    rd(cis_pkg::OFS_STATUS, st(7'b1000010));
    pulse(4'h4);
    rd(cis_pkg::OFS_STATUS, st(7'b1100010));
    frame <= 1'b1;
    repeat (20) @(posedge clock_i);
    frame <= 1'b0;
    rd(cis_pkg::OFS_STATUS, st(7'b1000010));
    pulse(4'h8);
    rd(cis_pkg::OFS_STATUS, st(7'b1010010));
    pulse(4'h1);
    rd(cis_pkg::OFS_STATUS, st(7'b0000010));
    // abort with launch in the same write, mid-sequence
    apb(1'b1, cis_pkg::OFS_OPCTL, 32'h2);
    pulse(4'h4);
    apb(1'b1, cis_pkg::OFS_OPCTL, 32'h3);
    rd(cis_pkg::OFS_STATUS, st(7'b0000010));
    // card busy after a command whose response has busy
    apb(1'b1, cis_pkg::OFS_OPCTL, 32'h2);
    busy <= 1'b1;
    ewb <= 1'b1;
    pulse(4'h2);
    rd(cis_pkg::OFS_STATUS, st(7'b1000000));
    pulse(4'h1);
    rd(cis_pkg::OFS_STATUS, st(7'b0000100));
    busy <= 1'b0;
    ewb <= 1'b0;
    repeat (6) @(posedge clock_i);
    rd(cis_pkg::OFS_STATUS, st(7'b0000010));
    // spi mode: level follows the receive line
    apb(1'b1, cis_pkg::OFS_OPCTL, 32'h4);
    for (int i = 0; i < 4; i++) begin
      spil <= 1'($urandom());
      repeat (8) @(posedge clock_i);
      rd(cis_pkg::OFS_STATUS, st({5'b0, spil, 1'b0}));
      check({31'h0, spim}, 32'h1);
    end
    apb(1'b1, cis_pkg::OFS_OPCTL, 32'h0);
    // flags only with enables, timeout recurs, clear and mask
    evt(8'hff, 8'hff);
    rd(cis_pkg::OFS_FL_LO, 32'h0);
    rd(cis_pkg::OFS_STATUS, st(7'b0000010));
    m = 8'($urandom()) | 8'h01;
    apb(1'b1, cis_pkg::OFS_EN_LO, {24'h0, m});
    evt(8'hff, 8'h00);
    rd(cis_pkg::OFS_FL_LO, {24'h0, m});
    check({31'h0, irq}, 32'h1);
    rd(cis_pkg::OFS_STATUS, st(7'b0000011));
    apb(1'b1, cis_pkg::OFS_EN_HI, 32'h1);
    evt(8'h00, 8'h01);
    rd(cis_pkg::OFS_FL_HI, 32'h1);
    apb(1'b1, cis_pkg::OFS_CLR, 32'h100);
    rd(cis_pkg::OFS_FL_HI, 32'h0);
    evt(8'h00, 8'h01);
    rd(cis_pkg::OFS_FL_HI, 32'h1);
    apb(1'b1, cis_pkg::OFS_EN_LO, 32'h0);
    rd(cis_pkg::OFS_STATUS, st(7'b0000011));
    apb(1'b1, cis_pkg::OFS_EN_HI, 32'h0);
    rd(cis_pkg::OFS_STATUS, st(7'b0000011));
    check({31'h0, irq}, 32'h0);
    apb(1'b1, cis_pkg::OFS_CLR, 32'hffff);
    rd(cis_pkg::OFS_STATUS, st(7'b0000010));
    // three accepted launches, one refused while running, one dropped by abort
    check(launches, 32'd3);
    check(aborts, 32'd1);
    report_and_stop;
  end
endmodule : testbench
